/* File: logic/msic_pkg.sv */
// Constants and carrier types for the MAC statistics and interrupt bank.
// Assumes one core clock, a synchronous active-high reset and a plain
// register port with read data one cycle after the read strobe.
//
// How it works
// - A main MAC interrupt source reaches the CPU only while its enable is set.
// - Enable bits: 9 link, 8 overflow, 7 tx early, 4 tx done, 3..0 rx.
// - Overflow summary appears as main status bit 8, cleared on read, enabled by bit 8.
// - A counter status bit sets when its counter's top bit becomes one.
// - Reading a counter clears its counter status bit.
// - Counters saturate at 255 or 65535 instead of wrapping.
// - Counter status bits: 11 underrun, 10 late coll, 9 tx, 8 fifo, 7 desc, 5..0 rx.
// - Counter enable register mirrors status layout; each bit gates its status bit into the overflow summary.
// - Reading a counter returns its value then clears it.
// - Offset 50h holds a 16-bit good receive count, clear on read.
// - Offset 52h holds broadcast count high byte, multicast count low byte.
// - Offset 54h holds runt count high byte, CRC error count low byte.
// - Offset 56h holds long packet count low byte; upper byte reserved.
// - Offset 58h holds FIFO full count high, no-descriptor loss count low.
// - Offset 5Ah holds a 16-bit good transmit count, clear on read.
// - Offset 5Ch holds underrun drop count high, late collision count low.
// - Offset 5Eh holds tx pause count high, rx pause count low.
// - Four 16-bit hash words at 60h upward, read/write, reset zero.
`default_nettype none

package msic_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] MSIC_OFF_MAC_IRQ_EN  = 8'h40;
	localparam logic [7:0] MSIC_OFF_CNT_IRQ_ST  = 8'h44;
	localparam logic [7:0] MSIC_OFF_CNT_IRQ_EN  = 8'h48;
	localparam logic [7:0] MSIC_OFF_MAIN_ST     = 8'h4c;
	localparam logic [7:0] MSIC_OFF_RX_GOOD     = 8'h50;
	localparam logic [7:0] MSIC_OFF_BC_MC       = 8'h52;
	localparam logic [7:0] MSIC_OFF_RUNT_CRC    = 8'h54;
	localparam logic [7:0] MSIC_OFF_LONG        = 8'h56;
	localparam logic [7:0] MSIC_OFF_FIFO_DESC   = 8'h58;
	localparam logic [7:0] MSIC_OFF_TX_GOOD     = 8'h5a;
	localparam logic [7:0] MSIC_OFF_DROP_LC     = 8'h5c;
	localparam logic [7:0] MSIC_OFF_PAUSE       = 8'h5e;
	localparam logic [7:0] MSIC_OFF_HASH0       = 8'h60;
	localparam logic [7:0] MSIC_OFF_HASH1       = 8'h62;
	localparam logic [7:0] MSIC_OFF_HASH2       = 8'h64;
	localparam logic [7:0] MSIC_OFF_HASH3       = 8'h66;

	// ------------------------------------------------------------
	// Field layouts and reset values
	// ------------------------------------------------------------
	localparam logic [15:0] MSIC_MAC_EN_MASK    = 16'h039f;
	localparam logic [15:0] MSIC_CNT_MASK       = 16'h0fbf;
	localparam int          MSIC_BIT_OVF        = 8;
	localparam logic [15:0] MSIC_RST_VAL        = 16'h0000;

	// Counter status bit positions
	localparam int MSIC_CI_RX_GOOD  = 0;
	localparam int MSIC_CI_MCAST    = 1;
	localparam int MSIC_CI_BCAST    = 2;
	localparam int MSIC_CI_CRC      = 3;
	localparam int MSIC_CI_RUNT     = 4;
	localparam int MSIC_CI_LONG     = 5;
	localparam int MSIC_CI_NO_DESC  = 7;
	localparam int MSIC_CI_FIFO     = 8;
	localparam int MSIC_CI_TX_GOOD  = 9;
	localparam int MSIC_CI_LATE     = 10;
	localparam int MSIC_CI_UNDERRUN = 11;

	// Counter slot indices
	localparam int MSIC_NCNT        = 14;
	localparam int MSIC_K_RX_GOOD   = 0;
	localparam int MSIC_K_MCAST     = 1;
	localparam int MSIC_K_BCAST     = 2;
	localparam int MSIC_K_CRC       = 3;
	localparam int MSIC_K_RUNT      = 4;
	localparam int MSIC_K_LONG      = 5;
	localparam int MSIC_K_NO_DESC   = 6;
	localparam int MSIC_K_FIFO      = 7;
	localparam int MSIC_K_TX_GOOD   = 8;
	localparam int MSIC_K_LATE      = 9;
	localparam int MSIC_K_UNDERRUN  = 10;
	localparam int MSIC_K_RX_PAUSE  = 11;
	localparam int MSIC_K_TX_PAUSE  = 12;
	localparam int MSIC_K_SPARE     = 13;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} msic_bus_s;

	typedef struct packed {
		logic rx_good;
		logic rx_mcast;
		logic rx_bcast;
		logic rx_crc_err;
		logic rx_runt;
		logic rx_long;
		logic rx_no_desc;
		logic rx_fifo_full;
		logic tx_good;
		logic tx_late_coll;
		logic tx_underrun;
		logic rx_pause;
		logic tx_pause;
	} msic_evt_s;

	// Main interrupt sources, bit-aligned with the enable register
	typedef logic [15:0] msic_word_t;

endpackage

`default_nettype wire

/* File: logic/msic_bank.sv */
// MAC interrupt enables, counter overflow status and statistics counters.
// Assumes event pulses and main interrupt sources on the core clock and a
// register master that never asserts read and write together.
`default_nettype none

module msic_bank (
	input  wire logic                  i_core_clk,
	input  wire logic                  i_rst,
	input  wire msic_pkg::msic_bus_s   i_bus,
	input  wire msic_pkg::msic_evt_s   i_evt,
	input  wire msic_pkg::msic_word_t  i_irq_src,
	output logic [15:0]                o_rdata,
	output logic                       o_irq,
	output logic [63:0]                o_hash
);
	import msic_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] sat_inc(input logic [15:0] v,
		input logic [15:0] max);
		sat_inc = (v == max) ? v : v + 16'h0001;
	endfunction

	function automatic logic hit(input msic_bus_s b, input logic [7:0] a);
		hit = b.rd && (b.addr == a);
	endfunction

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	logic [15:0] mac_irq_enable_reg;
	logic [15:0] counter_irq_enable_reg;
	logic [15:0] counter_irq_status_reg;
	logic [15:0] main_status_reg;
	logic [15:0] hash_reg [4];
	logic [15:0] cnt_reg [MSIC_NCNT];
	logic [15:0] rdata_reg;
	logic        irq_reg;

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			mac_irq_enable_reg     <= MSIC_RST_VAL;
			counter_irq_enable_reg <= MSIC_RST_VAL;
		end else if (i_bus.wr) begin
			if (i_bus.addr == MSIC_OFF_MAC_IRQ_EN)
				mac_irq_enable_reg <= i_bus.wdata & MSIC_MAC_EN_MASK;
			if (i_bus.addr == MSIC_OFF_CNT_IRQ_EN)
				counter_irq_enable_reg <= i_bus.wdata & MSIC_CNT_MASK;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			for (int h = 0; h < 4; h++)
				hash_reg[h] <= MSIC_RST_VAL;
		end else if (i_bus.wr && i_bus.addr >= MSIC_OFF_HASH0
			&& i_bus.addr <= MSIC_OFF_HASH3 && !i_bus.addr[0]) begin
			hash_reg[i_bus.addr[2:1]] <= i_bus.wdata;
		end
	end

	// ------------------------------------------------------------
	// Counters
	// ------------------------------------------------------------
	logic [MSIC_NCNT-1:0] inc;
	logic [MSIC_NCNT-1:0] clr;
	logic [MSIC_NCNT-1:0] wide;

	always_comb begin
		inc = '0;
		inc[MSIC_K_RX_GOOD]  = i_evt.rx_good;
		inc[MSIC_K_MCAST]    = i_evt.rx_mcast;
		inc[MSIC_K_BCAST]    = i_evt.rx_bcast;
		inc[MSIC_K_CRC]      = i_evt.rx_crc_err;
		inc[MSIC_K_RUNT]     = i_evt.rx_runt;
		inc[MSIC_K_LONG]     = i_evt.rx_long;
		inc[MSIC_K_NO_DESC]  = i_evt.rx_no_desc;
		inc[MSIC_K_FIFO]     = i_evt.rx_fifo_full;
		inc[MSIC_K_TX_GOOD]  = i_evt.tx_good;
		inc[MSIC_K_LATE]     = i_evt.tx_late_coll;
		inc[MSIC_K_UNDERRUN] = i_evt.tx_underrun;
		inc[MSIC_K_RX_PAUSE] = i_evt.rx_pause;
		inc[MSIC_K_TX_PAUSE] = i_evt.tx_pause;
		wide = '0;
		wide[MSIC_K_RX_GOOD] = 1'b1;
		wide[MSIC_K_TX_GOOD] = 1'b1;
		clr = '0;
		clr[MSIC_K_RX_GOOD]  = hit(i_bus, MSIC_OFF_RX_GOOD);
		clr[MSIC_K_MCAST]    = hit(i_bus, MSIC_OFF_BC_MC);
		clr[MSIC_K_BCAST]    = hit(i_bus, MSIC_OFF_BC_MC);
		clr[MSIC_K_CRC]      = hit(i_bus, MSIC_OFF_RUNT_CRC);
		clr[MSIC_K_RUNT]     = hit(i_bus, MSIC_OFF_RUNT_CRC);
		clr[MSIC_K_LONG]     = hit(i_bus, MSIC_OFF_LONG);
		clr[MSIC_K_NO_DESC]  = hit(i_bus, MSIC_OFF_FIFO_DESC);
		clr[MSIC_K_FIFO]     = hit(i_bus, MSIC_OFF_FIFO_DESC);
		clr[MSIC_K_TX_GOOD]  = hit(i_bus, MSIC_OFF_TX_GOOD);
		clr[MSIC_K_LATE]     = hit(i_bus, MSIC_OFF_DROP_LC);
		clr[MSIC_K_UNDERRUN] = hit(i_bus, MSIC_OFF_DROP_LC);
		clr[MSIC_K_RX_PAUSE] = hit(i_bus, MSIC_OFF_PAUSE);
		clr[MSIC_K_TX_PAUSE] = hit(i_bus, MSIC_OFF_PAUSE);
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			for (int k = 0; k < MSIC_NCNT; k++)
				cnt_reg[k] <= MSIC_RST_VAL;
		end else begin
			for (int k = 0; k < MSIC_NCNT; k++) begin
				if (clr[k])
					cnt_reg[k] <= {15'h0000, inc[k]};
				else if (inc[k])
					cnt_reg[k] <= sat_inc(cnt_reg[k],
						wide[k] ? 16'hffff : 16'h00ff);
			end
		end
	end

	// ------------------------------------------------------------
	// Overflow status
	// ------------------------------------------------------------
	logic [15:0] msb_now;
	logic [15:0] cnt_clr;

	always_comb begin
		msb_now = '0;
		msb_now[MSIC_CI_RX_GOOD]  = cnt_reg[MSIC_K_RX_GOOD][15];
		msb_now[MSIC_CI_MCAST]    = cnt_reg[MSIC_K_MCAST][7];
		msb_now[MSIC_CI_BCAST]    = cnt_reg[MSIC_K_BCAST][7];
		msb_now[MSIC_CI_CRC]      = cnt_reg[MSIC_K_CRC][7];
		msb_now[MSIC_CI_RUNT]     = cnt_reg[MSIC_K_RUNT][7];
		msb_now[MSIC_CI_LONG]     = cnt_reg[MSIC_K_LONG][7];
		msb_now[MSIC_CI_NO_DESC]  = cnt_reg[MSIC_K_NO_DESC][7];
		msb_now[MSIC_CI_FIFO]     = cnt_reg[MSIC_K_FIFO][7];
		msb_now[MSIC_CI_TX_GOOD]  = cnt_reg[MSIC_K_TX_GOOD][15];
		msb_now[MSIC_CI_LATE]     = cnt_reg[MSIC_K_LATE][7];
		msb_now[MSIC_CI_UNDERRUN] = cnt_reg[MSIC_K_UNDERRUN][7];
		cnt_clr = '0;
		cnt_clr[MSIC_CI_RX_GOOD]  = clr[MSIC_K_RX_GOOD];
		cnt_clr[MSIC_CI_MCAST]    = clr[MSIC_K_MCAST];
		cnt_clr[MSIC_CI_BCAST]    = clr[MSIC_K_BCAST];
		cnt_clr[MSIC_CI_CRC]      = clr[MSIC_K_CRC];
		cnt_clr[MSIC_CI_RUNT]     = clr[MSIC_K_RUNT];
		cnt_clr[MSIC_CI_LONG]     = clr[MSIC_K_LONG];
		cnt_clr[MSIC_CI_NO_DESC]  = clr[MSIC_K_NO_DESC];
		cnt_clr[MSIC_CI_FIFO]     = clr[MSIC_K_FIFO];
		cnt_clr[MSIC_CI_TX_GOOD]  = clr[MSIC_K_TX_GOOD];
		cnt_clr[MSIC_CI_LATE]     = clr[MSIC_K_LATE];
		cnt_clr[MSIC_CI_UNDERRUN] = clr[MSIC_K_UNDERRUN];
	end

	// Msb level sets the bit; a counter read clears it with the counter
	always_ff @(posedge i_core_clk) begin
		if (i_rst)
			counter_irq_status_reg <= MSIC_RST_VAL;
		else
			counter_irq_status_reg <= ((counter_irq_status_reg | msb_now)
				& ~cnt_clr) & MSIC_CNT_MASK;
	end

	logic ovf_any;
	assign ovf_any = |(counter_irq_status_reg & counter_irq_enable_reg);

	// Main status: sources and overflow, cleared on read, set wins
	logic [15:0] src_now;
	always_comb begin
		src_now = i_irq_src & MSIC_MAC_EN_MASK;
		src_now[MSIC_BIT_OVF] = ovf_any;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst)
			main_status_reg <= MSIC_RST_VAL;
		else if (hit(i_bus, MSIC_OFF_MAIN_ST))
			main_status_reg <= src_now;
		else
			main_status_reg <= main_status_reg | src_now;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst)
			irq_reg <= 1'b0;
		else
			irq_reg <= |(main_status_reg & mac_irq_enable_reg);
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			rdata_reg <= MSIC_RST_VAL;
		end else if (i_bus.rd) begin
			case (i_bus.addr)
				MSIC_OFF_MAC_IRQ_EN: rdata_reg <= mac_irq_enable_reg;
				MSIC_OFF_CNT_IRQ_ST: rdata_reg <= counter_irq_status_reg;
				MSIC_OFF_CNT_IRQ_EN: rdata_reg <= counter_irq_enable_reg;
				MSIC_OFF_MAIN_ST:    rdata_reg <= main_status_reg;
				MSIC_OFF_RX_GOOD:    rdata_reg <= cnt_reg[MSIC_K_RX_GOOD];
				MSIC_OFF_BC_MC:      rdata_reg <= {cnt_reg[MSIC_K_BCAST][7:0],
					cnt_reg[MSIC_K_MCAST][7:0]};
				MSIC_OFF_RUNT_CRC:   rdata_reg <= {cnt_reg[MSIC_K_RUNT][7:0],
					cnt_reg[MSIC_K_CRC][7:0]};
				MSIC_OFF_LONG:       rdata_reg <= {8'h00,
					cnt_reg[MSIC_K_LONG][7:0]};
				MSIC_OFF_FIFO_DESC:  rdata_reg <= {cnt_reg[MSIC_K_FIFO][7:0],
					cnt_reg[MSIC_K_NO_DESC][7:0]};
				MSIC_OFF_TX_GOOD:    rdata_reg <= cnt_reg[MSIC_K_TX_GOOD];
				MSIC_OFF_DROP_LC:    rdata_reg <= {cnt_reg[MSIC_K_UNDERRUN][7:0],
					cnt_reg[MSIC_K_LATE][7:0]};
				MSIC_OFF_PAUSE:      rdata_reg <= {cnt_reg[MSIC_K_TX_PAUSE][7:0],
					cnt_reg[MSIC_K_RX_PAUSE][7:0]};
				MSIC_OFF_HASH0:      rdata_reg <= hash_reg[0];
				MSIC_OFF_HASH1:      rdata_reg <= hash_reg[1];
				MSIC_OFF_HASH2:      rdata_reg <= hash_reg[2];
				MSIC_OFF_HASH3:      rdata_reg <= hash_reg[3];
				default:             rdata_reg <= 16'h0000;
			endcase
		end else begin
			rdata_reg <= 16'h0000;
		end
	end

	assign o_rdata = rdata_reg;
	assign o_irq   = irq_reg;
	assign o_hash  = {hash_reg[3], hash_reg[2], hash_reg[1], hash_reg[0]};

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_irq_gated;
		@(posedge i_core_clk) disable iff (i_rst)
		o_irq |-> |($past(main_status_reg) & $past(mac_irq_enable_reg));
	endproperty
	a_irq_gated: assert property (p_irq_gated)
		else $error("interrupt without enabled source");

	property p_en_reserved;
		@(posedge i_core_clk) disable iff (i_rst)
		(mac_irq_enable_reg & ~MSIC_MAC_EN_MASK) == 16'h0000;
	endproperty
	a_en_reserved: assert property (p_en_reserved)
		else $error("reserved enable bit set");

	property p_ovf_main;
		@(posedge i_core_clk) disable iff (i_rst)
		ovf_any |=> main_status_reg[MSIC_BIT_OVF];
	endproperty
	a_ovf_main: assert property (p_ovf_main)
		else $error("overflow not reported in main status");

	property p_msb_sets;
		@(posedge i_core_clk) disable iff (i_rst)
		($rose(cnt_reg[MSIC_K_LONG][7]) && !clr[MSIC_K_LONG])
			|-> counter_irq_status_reg[MSIC_CI_LONG]
			or ##1 counter_irq_status_reg[MSIC_CI_LONG];
	endproperty
	a_msb_sets: assert property (p_msb_sets)
		else $error("status bit missed counter top bit");

	property p_sat8;
		@(posedge i_core_clk) disable iff (i_rst)
		(cnt_reg[MSIC_K_CRC] == 16'h00ff && !clr[MSIC_K_CRC])
			|=> cnt_reg[MSIC_K_CRC] == 16'h00ff;
	endproperty
	a_sat8: assert property (p_sat8)
		else $error("8-bit counter wrapped");

	property p_rd_clear;
		@(posedge i_core_clk) disable iff (i_rst)
		clr[MSIC_K_TX_GOOD] |=>
			cnt_reg[MSIC_K_TX_GOOD] == {15'h0000, $past(inc[MSIC_K_TX_GOOD])};
	endproperty
	a_rd_clear: assert property (p_rd_clear)
		else $error("counter not cleared on read");

	property p_rd_value;
		@(posedge i_core_clk) disable iff (i_rst)
		hit(i_bus, MSIC_OFF_RX_GOOD) |=> o_rdata == $past(cnt_reg[0]);
	endproperty
	a_rd_value: assert property (p_rd_value)
		else $error("read data mismatch");

	property p_summary;
		@(posedge i_core_clk) disable iff (i_rst)
		|(counter_irq_status_reg & counter_irq_enable_reg)
			|=> main_status_reg[MSIC_BIT_OVF];
	endproperty
	a_summary: assert property (p_summary)
		else $error("summary missing");

	property p_rd_clr_status;
		@(posedge i_core_clk) disable iff (i_rst)
		clr[MSIC_K_LONG] |=> !counter_irq_status_reg[MSIC_CI_LONG];
	endproperty
	a_rd_clr_status: assert property (p_rd_clr_status)
		else $error("status bit kept after counter read");

	property p_clr_inc;
		@(posedge i_core_clk) disable iff (i_rst)
		(clr[MSIC_K_LONG] && inc[MSIC_K_LONG])
			|=> cnt_reg[MSIC_K_LONG] == 16'h0001;
	endproperty
	a_clr_inc: assert property (p_clr_inc)
		else $error("increment lost at read clear");

	property p_sat16;
		@(posedge i_core_clk) disable iff (i_rst)
		(cnt_reg[MSIC_K_TX_GOOD] == 16'hffff && !clr[MSIC_K_TX_GOOD])
			|=> cnt_reg[MSIC_K_TX_GOOD] == 16'hffff;
	endproperty
	a_sat16: assert property (p_sat16)
		else $error("16-bit counter wrapped");

	property p_cnt_en_reserved;
		@(posedge i_core_clk) disable iff (i_rst)
		(counter_irq_enable_reg & ~MSIC_CNT_MASK) == 16'h0000;
	endproperty
	a_cnt_en_reserved: assert property (p_cnt_en_reserved)
		else $error("reserved counter enable bit set");

	property p_st_reserved;
		@(posedge i_core_clk) disable iff (i_rst)
		(counter_irq_status_reg & ~MSIC_CNT_MASK) == 16'h0000;
	endproperty
	a_st_reserved: assert property (p_st_reserved)
		else $error("reserved counter status bit set");

	property p_hash_wr;
		@(posedge i_core_clk) disable iff (i_rst)
		(i_bus.wr && i_bus.addr == MSIC_OFF_HASH0)
			|=> o_hash[15:0] == $past(i_bus.wdata);
	endproperty
	a_hash_wr: assert property (p_hash_wr)
		else $error("hash word not written");

	c_rd_inc: cover property (@(posedge i_core_clk)
		clr[MSIC_K_LONG] && inc[MSIC_K_LONG]);
	c_ovf_main: cover property (@(posedge i_core_clk)
		main_status_reg[MSIC_BIT_OVF]);
	c_sat16: cover property (@(posedge i_core_clk)
		cnt_reg[MSIC_K_TX_GOOD] == 16'hffff);
	c_irq: cover property (@(posedge i_core_clk) o_irq);
	c_sat: cover property (@(posedge i_core_clk)
		cnt_reg[MSIC_K_RUNT] == 16'h00ff);

endmodule

`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the MAC statistics and interrupt bank.
// Assumes the bank samples its register port, events and sources on
// the core clock edge and answers reads one cycle later.
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import msic_pkg::*;

	// ------------------------------------------------------------
	// Stimulus and observation
	// ------------------------------------------------------------
	logic        i_core_clk;
	logic        i_rst;
	msic_bus_s   bus;
	msic_evt_s   evt;
	msic_word_t  src;
	logic [15:0] rdata;
	logic        irq;
	logic [63:0] hash;
	logic [15:0] got;
	logic [15:0] exp_v[8];
	int          miscompares;
	int          total_checks;
	int          reg_of[13] = '{7, 7, 6, 6, 5, 4, 4, 3, 2, 2, 1, 1, 0};
	int          sh_of[13]  = '{8, 0, 8, 0, 0, 8, 0, 0, 8, 0, 8, 0, 0};
	int          st_of[13]  = '{0, 0, 11, 10, 9, 8, 7, 5, 4, 3, 2, 1, 0};
	int          srcb[7]    = '{0, 1, 2, 3, 4, 7, 9};

	msic_bank i_dut (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_bus      (bus),
		.i_evt      (evt),
		.i_irq_src  (src),
		.o_rdata    (rdata),
		.o_irq      (irq),
		.o_hash     (hash)
	);

	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [15:0] e,
			input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_core_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_core_clk);
		bus <= '0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge i_core_clk);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge i_core_clk);
		bus <= '0;
		#1 d = rdata;
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
		rd(a, got);
		chk($sformatf("reg %h", a), e, got);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask

	task automatic chk_irq(input logic e);
		chk("irq", {15'h0000, e}, {15'h0000, irq});
	endtask

	// Holds one event line high for n edges, n increments
	task automatic pulse(input int j, input int n);
		@(posedge i_core_clk);
		evt <= msic_evt_s'(13'h0001 << j);
		repeat (n) @(posedge i_core_clk);
		evt <= '0;
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		int a;
		int w;
		int half;
		bus = '0;
		evt = '0;
		src = '0;
		i_rst = 1'b1;
		miscompares = 0;
		total_checks = 0;
		repeat (3) @(posedge i_core_clk);
		i_rst <= 1'b0;

		for (a = 8'h40; a <= 8'h66; a += 2) begin
			chk_rd(8'(a), 16'h0000);
		end
		wr(8'h40, 16'hffff);
		chk_rd(8'h40, MSIC_MAC_EN_MASK);
		wr(8'h48, 16'hffff);
		chk_rd(8'h48, MSIC_CNT_MASK);
		wr(8'h44, 16'hffff);
		chk_rd(8'h44, 16'h0000);
		wr(8'h42, 16'hffff);
		chk_rd(8'h42, 16'h0000);
		for (a = 0; a < 4; a++) begin
			wr(8'(8'h60 + 2 * a), 16'(16'h1357 * (a + 1)));
		end
		for (a = 0; a < 4; a++) begin
			chk_rd(8'(8'h60 + 2 * a), 16'(16'h1357 * (a + 1)));
			chk("hash", 16'(16'h1357 * (a + 1)), hash[16 * a +: 16]);
		end
		wr(8'h40, 16'h0000);
		wr(8'h48, 16'h0000);
		$display("test registers done");

		for (a = 0; a < 8; a++) begin
			exp_v[a] = 16'h0000;
		end
		for (a = 0; a < 13; a++) begin
			pulse(a, a + 3);
			exp_v[reg_of[a]] |= 16'((a + 3) << sh_of[a]);
		end
		for (a = 0; a < 8; a++) begin
			chk_rd(8'(8'h50 + 2 * a), exp_v[a]);
			chk_rd(8'(8'h50 + 2 * a), 16'h0000);
		end
		$display("test counter map done");

		wr(8'h48, MSIC_CNT_MASK);
		wr(8'h40, 16'h0100);
		for (int j = 2; j < 12; j++) begin
			w = (j == 4) ? 16 : 8;
			half = 1 << (w - 1);
			a = 8'h50 + 2 * reg_of[j];
			pulse(j, half - 1);
			chk_rd(8'h44, 16'h0000);
			pulse(j, 1);
			wait_cyc(5);
			chk_irq(1'b1);
			chk_rd(8'h44, 16'(1 << st_of[j]));
			pulse(j, half + 10);
			chk_rd(8'(a), 16'(((1 << w) - 1) << sh_of[j]));
			chk_rd(8'h44, 16'h0000);
			chk_rd(8'h4c, 16'h0100);
			wait_cyc(5);
			chk_irq(1'b0);
		end
		$display("test overflow done");

		wr(8'h48, 16'h0000);
		pulse(7, 128);
		wait_cyc(5);
		chk_irq(1'b0);
		chk_rd(8'h44, 16'h0020);
		wr(8'h48, 16'h0020);
		wait_cyc(5);
		chk_irq(1'b1);
		chk_rd(8'h56, 16'h0080);
		chk_rd(8'h4c, 16'h0100);
		wait_cyc(5);
		chk_irq(1'b0);
		$display("test overflow mask done");

		for (int k = 0; k < 7; k++) begin
			wr(8'h40, MSIC_MAC_EN_MASK & ~(16'h0001 << srcb[k]));
			@(posedge i_core_clk);
			src <= msic_word_t'(16'h0001 << srcb[k]);
			@(posedge i_core_clk);
			src <= '0;
			wait_cyc(5);
			chk_irq(1'b0);
			wr(8'h40, 16'h0001 << srcb[k]);
			wait_cyc(5);
			chk_irq(1'b1);
			chk_rd(8'h4c, 16'h0001 << srcb[k]);
			wait_cyc(5);
			chk_irq(1'b0);
		end
		$display("test main sources done");

		pulse(7, 5);
		@(posedge i_core_clk);
		bus <= '{addr: 8'h56, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		evt <= msic_evt_s'(13'h0080);
		@(posedge i_core_clk);
		bus <= '0;
		evt <= '0;
		#1 chk("reg 56", 16'h0005, rdata);
		chk_rd(8'h56, 16'h0001);
		$display("test clear collision done");
		conclude();
	end

	// ------------------------------------------------------------
	// Watchdog
	// ------------------------------------------------------------
	initial begin
		#900000;
		miscompares++;
		conclude();
	end

endmodule

`default_nettype wire
